// ===== inc/mcs_pkg.sv
/*
 * Types of the measurement control and status register group.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package mcs_pkg;

  typedef enum logic [1:0] {
    MCS_MODE_SLEEP,
    MCS_MODE_FORCED_A,
    MCS_MODE_FORCED_B,
    MCS_MODE_NORMAL
  } mcs_mode_t;

  typedef struct packed {
    logic [2:0] t_os;
    logic [2:0] p_os;
    mcs_mode_t  mode;
  } mcs_ctrl_t;

  typedef struct packed {
    logic csb;
    logic sck;
    logic sdi;
    logic scl;
    logic sda;
  } mcs_pins_t;

  typedef enum logic [2:0] {
    MCS_SQ_IDLE,
    MCS_SQ_TEMP,
    MCS_SQ_PRESS,
    MCS_SQ_STORE,
    MCS_SQ_WAIT
  } mcs_seq_t;

endpackage : mcs_pkg

`default_nettype wire

// ===== inc/mcs_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * measurement control and status register group.
 * Assumes a 125 MHz system clock; offsets are the byte register addresses.
 */
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define MCS_OFS_HS       8'hF2
`define MCS_OFS_STAT     8'hF3
`define MCS_OFS_CTRL     8'hF4

// ********************************************************************
// Reset values and fields
// ********************************************************************
`define MCS_HS_RST       3'h1
`define MCS_CTRL_RST     8'h00
`define MCS_STAT_MEAS    3
`define MCS_STAT_NVM     0
`define MCS_HS_BASE      8'h08
`define MCS_OS_SKIP      3'h0
`define MCS_OS_ONE       3'h1
`define MCS_OS_TWO       3'h2
`define MCS_MASK_22      24'hFFFFFC
`define MCS_MASK_23      24'hFFFFFE
`define MCS_MASK_24      24'hFFFFFF

// ********************************************************************
// Timing
// ********************************************************************
`define MCS_CLK_MHZ      125
`define MCS_STBY_UNIT_US 1000
`define MCS_SAMPLE_CYC   16

`endif

// ===== rtl/mcs_ctrl_status.sv
/*
 * Measurement control, status and high-speed master code registers with a
 * 4-wire serial register port, conversion sequencer and master code detector.
 * Assumes the serial pins are asynchronous and slow next to clk, and that the
 * converter values and the calibration memory busy level are on clk.
 */
`include "mcs_regs.svh"
`default_nettype none

module mcs_ctrl_status
  import mcs_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `MCS_STBY_UNIT_US * `MCS_CLK_MHZ,
  parameter int unsigned SAMPLE_CYC = `MCS_SAMPLE_CYC
) (
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Async reset, active high
  input  wire mcs_pins_t   pins,         // Serial pins, asynchronous
  output var  logic        sdo_o,        // Serial data out
  output var  logic        sdo_oe,       // Serial data out enable
  output var  logic        hs_mode,      // High-speed signalling active
  input  wire logic [2:0]  stby_sel,     // Continuous idle time select
  input  wire logic        nvm_busy,     // Calibration memory access
  input  wire logic [23:0] adc_temp,     // Temperature conversion value
  input  wire logic [23:0] adc_press,    // Pressure conversion value
  output var  logic [23:0] temp_data,    // Stored temperature result
  output var  logic [23:0] press_data    // Stored pressure result
);

  // ******************************************************************
  // Pin synchronisation and edges
  // ******************************************************************
  mcs_pins_t pin_s;
  mcs_pins_t prev_ff;

  mcs_sync #(.W(5), .RST(5'h1F)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins),
    .q   (pin_s)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) prev_ff <= 5'h1F;
    else     prev_ff <= pin_s;
  end

  wire sck_rise = pin_s.sck & ~prev_ff.sck & ~pin_s.csb;
  wire sck_fall = ~pin_s.sck & prev_ff.sck & ~pin_s.csb;
  wire scl_rise = pin_s.scl & ~prev_ff.scl;
  wire i2c_start = pin_s.scl & prev_ff.scl & prev_ff.sda & ~pin_s.sda;
  wire i2c_stop  = pin_s.scl & prev_ff.scl & ~prev_ff.sda & pin_s.sda;

  // ******************************************************************
  // Registers
  // ******************************************************************
  mcs_ctrl_t  ctrl_ff;
  logic [2:0] hs_code_ff;
  logic       nvm_ff;
  mcs_seq_t   state_ff, nxt_state;
  logic       wr_stb;
  logic       forced_clr;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  wire [6:0] a_hs   = 7'(`MCS_OFS_HS);
  wire [6:0] a_stat = 7'(`MCS_OFS_STAT);
  wire [6:0] a_ctrl = 7'(`MCS_OFS_CTRL);
  wire       busy   = (state_ff == MCS_SQ_TEMP) || (state_ff == MCS_SQ_PRESS)
                   || (state_ff == MCS_SQ_STORE);
  wire [7:0] stat_byte = 8'(busy) << `MCS_STAT_MEAS | 8'(nvm_ff) << `MCS_STAT_NVM;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff    <= `MCS_CTRL_RST;
      hs_code_ff <= `MCS_HS_RST;
      nvm_ff     <= 1'b0;
    end else begin
      nvm_ff <= nvm_busy;
      if (wr_stb && wr_addr == a_ctrl) ctrl_ff <= wr_data;
      else if (forced_clr) ctrl_ff.mode <= MCS_MODE_SLEEP;
      if (wr_stb && wr_addr == a_hs) hs_code_ff <= wr_data[2:0];
    end
  end

  // ******************************************************************
  // Serial register port
  // ******************************************************************
  logic [2:0] sp_cnt_ff;
  logic [6:0] sp_sh_ff;
  logic       sp_first_ff, sp_rd_ff, sp_dat_ff;
  logic [6:0] sp_addr_ff;
  logic [7:0] sp_tx_ff;
  logic       sdo_ff;

  wire       byte_done = sck_rise && (sp_cnt_ff == 3'h7);
  wire [7:0] nb        = {sp_sh_ff, pin_s.sdi};
  wire [6:0] rd_addr   = sp_first_ff ? nb[6:0] : sp_addr_ff;
  wire [7:0] rd_data   = (rd_addr == a_hs)   ? {5'h00, hs_code_ff} :
                         (rd_addr == a_stat) ? stat_byte :
                         (rd_addr == a_ctrl) ? ctrl_ff : 8'h00;
  wire       rd_load   = byte_done && (sp_first_ff ? nb[7] : sp_rd_ff);
  assign wr_stb  = byte_done && !sp_first_ff && !sp_rd_ff && sp_dat_ff;
  assign wr_addr = sp_addr_ff;
  assign wr_data = nb;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_cnt_ff <= 3'h0; sp_sh_ff <= 7'h00; sp_first_ff <= 1'b1;
      sp_rd_ff <= 1'b0; sp_dat_ff <= 1'b0; sp_addr_ff <= 7'h00;
      sp_tx_ff <= 8'h00; sdo_ff <= 1'b0;
    end else if (pin_s.csb) begin
      sp_cnt_ff <= 3'h0; sp_first_ff <= 1'b1; sp_dat_ff <= 1'b0;
    end else begin
      if (sck_rise) begin
        sp_sh_ff  <= nb[6:0];
        sp_cnt_ff <= sp_cnt_ff + 3'h1;
      end
      if (byte_done) begin
        sp_first_ff <= 1'b0;
        if (sp_first_ff) sp_rd_ff <= nb[7];
        if (rd_load) begin
          sp_tx_ff   <= rd_data;
          sp_addr_ff <= rd_addr + 7'h01;
        end else if (sp_first_ff || !sp_dat_ff) begin
          sp_addr_ff <= nb[6:0];
          sp_dat_ff  <= 1'b1;
        end else begin
          sp_dat_ff  <= 1'b0;
        end
      end
      if (sck_fall) begin
        sdo_ff   <= sp_tx_ff[7];
        sp_tx_ff <= {sp_tx_ff[6:0], 1'b0};
      end
    end
  end

  assign sdo_o  = sdo_ff;
  assign sdo_oe = ~pin_s.csb & sp_rd_ff & ~sp_first_ff;

  // ******************************************************************
  // High-speed master code detector
  // ******************************************************************
  logic       i2c_act_ff, hs_ff;
  logic [3:0] i2c_cnt_ff;
  logic [6:0] i2c_sh_ff;
  wire  [7:0] mc_byte  = {i2c_sh_ff, pin_s.sda};
  wire  [7:0] mc_match = `MCS_HS_BASE + {5'h00, hs_code_ff};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i2c_act_ff <= 1'b0; hs_ff <= 1'b0; i2c_cnt_ff <= 4'h0; i2c_sh_ff <= 7'h00;
    end else if (i2c_stop) begin
      i2c_act_ff <= 1'b0; hs_ff <= 1'b0;
    end else if (i2c_start) begin
      i2c_act_ff <= 1'b1; i2c_cnt_ff <= 4'h0;
    end else if (scl_rise && i2c_act_ff) begin
      i2c_sh_ff  <= mc_byte[6:0];
      i2c_cnt_ff <= i2c_cnt_ff + 4'h1;
      if (i2c_cnt_ff == 4'h7) begin
        i2c_act_ff <= 1'b0;
        if (mc_byte == mc_match) hs_ff <= 1'b1;
      end
    end
  end

  assign hs_mode = hs_ff;

  // ******************************************************************
  // Conversion sequencer
  // ******************************************************************
  logic [31:0] cnt_ff, nxt_cnt;
  logic [2:0]  t_os_ff, p_os_ff;
  logic        forced_ff;
  logic [31:0] stby_ms;

  wire [31:0] t_len  = SAMPLE_CYC << (t_os_ff - 3'h1);
  wire [31:0] p_len  = SAMPLE_CYC << (p_os_ff - 3'h1);
  wire        go     = ctrl_ff.mode != MCS_MODE_SLEEP;
  wire        forced = (ctrl_ff.mode == MCS_MODE_FORCED_A)
                    || (ctrl_ff.mode == MCS_MODE_FORCED_B);
  wire [31:0] stby_cyc = 32'(stby_ms * CYC_PER_MS);
  wire [23:0] t_mask = (t_os_ff == `MCS_OS_ONE) ? `MCS_MASK_22 :
                       (t_os_ff == `MCS_OS_TWO) ? `MCS_MASK_23 : `MCS_MASK_24;
  wire [23:0] p_mask = (p_os_ff == `MCS_OS_ONE) ? `MCS_MASK_22 :
                       (p_os_ff == `MCS_OS_TWO) ? `MCS_MASK_23 : `MCS_MASK_24;
  assign forced_clr  = (state_ff == MCS_SQ_STORE) && forced_ff;

  always_comb begin
    case (stby_sel)
      3'h0:    stby_ms = 32'd1;
      3'h1:    stby_ms = 32'd5;
      3'h2:    stby_ms = 32'd50;
      3'h3:    stby_ms = 32'd250;
      3'h4:    stby_ms = 32'd500;
      3'h5:    stby_ms = 32'd1000;
      3'h6:    stby_ms = 32'd2000;
      default: stby_ms = 32'd4000;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff != 32'h0) ? cnt_ff - 32'h1 : 32'h0;
    case (state_ff)
      MCS_SQ_IDLE: begin
        if (go) begin
          if (ctrl_ff.t_os != `MCS_OS_SKIP) begin
            nxt_state = MCS_SQ_TEMP;
            nxt_cnt   = SAMPLE_CYC << (ctrl_ff.t_os - 3'h1);
          end else if (ctrl_ff.p_os != `MCS_OS_SKIP) begin
            nxt_state = MCS_SQ_PRESS;
            nxt_cnt   = SAMPLE_CYC << (ctrl_ff.p_os - 3'h1);
          end else begin
            nxt_state = MCS_SQ_STORE;
          end
        end
      end
      MCS_SQ_TEMP: begin
        if (cnt_ff <= 32'h1) begin
          if (p_os_ff != `MCS_OS_SKIP) begin
            nxt_state = MCS_SQ_PRESS;
            nxt_cnt   = p_len;
          end else begin
            nxt_state = MCS_SQ_STORE;
          end
        end
      end
      MCS_SQ_PRESS: if (cnt_ff <= 32'h1) nxt_state = MCS_SQ_STORE;
      MCS_SQ_STORE: begin
        if (forced_ff) begin
          nxt_state = MCS_SQ_IDLE;
        end else begin
          nxt_state = MCS_SQ_WAIT;
          nxt_cnt   = stby_cyc;
        end
      end
      MCS_SQ_WAIT: if (cnt_ff <= 32'h1) nxt_state = MCS_SQ_IDLE;
      default:     nxt_state = MCS_SQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= MCS_SQ_IDLE; cnt_ff <= 32'h0;
      t_os_ff <= 3'h0; p_os_ff <= 3'h0; forced_ff <= 1'b0;
      temp_data <= 24'h000000; press_data <= 24'h000000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (state_ff == MCS_SQ_IDLE && go) begin
        t_os_ff <= ctrl_ff.t_os; p_os_ff <= ctrl_ff.p_os; forced_ff <= forced;
      end
      if (state_ff == MCS_SQ_TEMP && nxt_state != MCS_SQ_TEMP)
        temp_data <= adc_temp & t_mask;
      if (state_ff == MCS_SQ_PRESS && nxt_state != MCS_SQ_PRESS)
        press_data <= adc_press & p_mask;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_TEMP_LEN: assert property ($rose(state_ff == MCS_SQ_TEMP) |-> cnt_ff == t_len)
    else $error("temperature conversion length wrong");
  AST_PRESS_LEN: assert property ($rose(state_ff == MCS_SQ_PRESS) |-> cnt_ff == p_len)
    else $error("pressure conversion length wrong");
  AST_SKIP: assert property ((state_ff == MCS_SQ_TEMP) |-> t_os_ff != `MCS_OS_SKIP)
    else $error("skipped temperature converted");
  AST_SLEEP: assert property (state_ff == MCS_SQ_IDLE && !go |=> state_ff == MCS_SQ_IDLE)
    else $error("sequencer left sleep");
  AST_FORCED: assert property (forced_clr && !wr_stb |=> ctrl_ff.mode == MCS_MODE_SLEEP)
    else $error("single shot did not return to sleep");
  AST_MEAS: assert property ($changed({temp_data, press_data}) |->
    $past(stat_byte[`MCS_STAT_MEAS]))
    else $error("result stored outside a measurement");
  AST_NVM: assert property (##1 stat_byte[`MCS_STAT_NVM] == $past(nvm_busy))
    else $error("calibration access flag mismatch");
  AST_HS: assert property ($rose(hs_ff) |-> $past(mc_byte) ==
    `MCS_HS_BASE + $past(hs_code_ff)) else $error("high-speed entered on wrong code");
  AST_STBY: assert property ($rose(state_ff == MCS_SQ_WAIT) |->
    cnt_ff == $past(stby_cyc)) else $error("idle interval wrong");
  AST_HS_STOP: assert property (i2c_stop |=> !hs_ff)
    else $error("high-speed not ended by stop");

  COV_FORCED: cover property (forced_clr);
  COV_WAIT:   cover property ($rose(state_ff == MCS_SQ_WAIT));
  COV_HS:     cover property ($rose(hs_ff));
  COV_READ:   cover property (rd_load);

endmodule : mcs_ctrl_status

`default_nettype wire

// ===== rtl/mcs_sync.sv
/*
 * Two flip-flop synchroniser for a bank of pin inputs.
 * Assumes the inputs are asynchronous to clk; only the second stage is used.
 */
`default_nettype none

module mcs_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst,    // Async reset, active high
  input  wire logic [W-1:0] d,      // Asynchronous inputs
  output var  logic [W-1:0] q       // Synchronised outputs
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST;
      q       <= RST;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : mcs_sync

`default_nettype wire

// ===== verif/mcs_host.sv
/*
 * Host model: serial register master and high-speed preamble sender.
 * Assumes tb_top calls its tasks; the device samples these pins asynchronously.
 */
`default_nettype none

module mcs_host
  import mcs_pkg::*;
(
  output var mcs_pins_t pins,  // Pin levels towards the device
  input  wire logic     sdo    // Serial data from the device
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HP = 62.5;

  initial pins = '{csb: 1'b1, sck: 1'b0, sdi: 1'b0, scl: 1'b1, sda: 1'b1};

  // ****************************************************************
  // Register port
  // ****************************************************************
  task automatic sel(input logic on);
    pins.sdi = ~pins.sdi;  // Idle data line keeps changing
    #HP pins.csb = ~on;
    #HP;
  endtask : sel

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.sdi = tx[i];
      #HP pins.sck = 1'b1;
      rx = {rx[6:0], sdo};
      #HP pins.sck = 1'b0;
    end
  endtask : xbyte

  // ****************************************************************
  // Preamble on the two-wire bus, pull-ups keep idle high
  // ****************************************************************
  task automatic mcode(input logic [7:0] b);
    logic [8:0] s;
    s = {b, 1'b1};
    #HP pins.sda = 1'b0;
    #HP pins.scl = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      pins.sda = s[i];
      #HP pins.scl = 1'b1;
      #HP pins.scl = 1'b0;
    end
  endtask : mcode

  task automatic stop_i2c();
    pins.sda = 1'b0;
    #HP pins.scl = 1'b1;
    #HP pins.sda = 1'b1;
    #HP;
  endtask : stop_i2c

endmodule : mcs_host

`default_nettype wire

// ===== verif/tb_top.sv
/*
 * Self-checking bench of the measurement control and status registers.
 * Assumes mcs_host as the serial host and short counts for the sequencer.
 */
`include "mcs_regs.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mcs_pkg::*;
  localparam int CPM = 10;
  localparam int SC  = 16;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        nvm_busy = 1'b0;
  logic        spin = 1'b0;
  logic [2:0]  stby_sel = 3'h0;
  logic [23:0] adc_temp = 24'h0;
  logic [23:0] adc_press = 24'h0;
  logic        sdo_o, sdo_oe, hs_mode;
  logic [23:0] temp_data, press_data;
  mcs_pins_t   pins;
  int          n_mismatch = 0;
  int          tests_run = 0;

  always #4 clk = ~clk;

  mcs_ctrl_status #(.CYC_PER_MS(CPM), .SAMPLE_CYC(SC)) dut (
    .clk(clk), .rst(rst), .pins(pins), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .hs_mode(hs_mode), .stby_sel(stby_sel), .nvm_busy(nvm_busy),
    .adc_temp(adc_temp), .adc_press(adc_press),
    .temp_data(temp_data), .press_data(press_data)
  );
  // Released line shows the inverse, so a read without enable fails
  wire         sdo_line = sdo_oe ? sdo_o : ~sdo_o;
  mcs_host host (.pins(pins), .sdo(sdo_line));

  always @(posedge clk) begin
    if (spin) begin
      adc_temp <= 24'($urandom());
      adc_press <= 24'($urandom());
    end
  end

  // ****************************************************************
  // Tasks and reference model
  // ****************************************************************
  task automatic stop_test();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.sel(1'b1);
    host.xbyte({1'b0, a[6:0]}, x);
    host.xbyte(d, x);
    host.sel(1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host.sel(1'b1);
    host.xbyte({1'b1, a[6:0]}, d);
    host.xbyte(8'h00, d);
    host.sel(1'b0);
  endtask : rd

  task automatic gap(input int lim, output int n);
    logic [23:0] v;
    v = temp_data;
    n = 0;
    while (temp_data === v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : gap

  function automatic logic [23:0] msk(input logic [2:0] c, input logic [23:0] v);
    return (c == 3'h1) ? (v & 24'hFFFFFC) : ((c == 3'h2) ? (v & 24'hFFFFFE) : v);
  endfunction : msk

  function automatic int ph(input logic [2:0] c);
    return (c == 3'h0) ? 0 : (SC << (c - 1));
  endfunction : ph

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] d;
    int t, p, k, n, len, exp_t, exp_p;
    int ms[4];
    k = $urandom(32'hE638);
    ms = '{1, 5, 50, 250};
    exp_t = 0;
    exp_p = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    wr(`MCS_OFS_STAT, 8'hFF);
    wr(8'hF5, 8'h5A);
    rd(`MCS_OFS_HS, d);
    chk(d, 8'h01);
    rd(`MCS_OFS_STAT, d);
    chk(d, 8'h00);
    rd(`MCS_OFS_CTRL, d);
    chk(d, 8'h00);
    rd(8'hF5, d);
    chk(d, 8'h00);
    $display("test reset done");

    for (k = 0; k < 8; k++) begin
      wr(`MCS_OFS_HS, {5'h00, k[2:0]});
      rd(`MCS_OFS_HS, d);
      chk(d, k);
      host.mcode(8'h08 + 8'(k));
      chk(hs_mode, 1'b1);
      host.stop_i2c();
      chk(hs_mode, 1'b0);
      host.mcode(8'h08 + 8'((k + 1) % 8));
      chk(hs_mode, 1'b0);
      host.stop_i2c();
    end
    $display("test master code done");

    for (k = 0; k < 12; k++) begin
      t = $urandom_range(7);
      p = $urandom_range(7);
      if (k == 0) t = 0;
      if (k == 1) p = 0;
      if (k == 2) begin
        t = 7;
        p = 7;
      end
      @(posedge clk);
      spin <= 1'b1;
      nvm_busy <= k[0];
      @(posedge clk);
      spin <= 1'b0;
      @(posedge clk);
      if (t != 0) exp_t = msk(3'(t), adc_temp);
      if (p != 0) exp_p = msk(3'(p), adc_press);
      len = ph(3'(t)) + ph(3'(p));
      wr(`MCS_OFS_CTRL, {3'(t), 3'(p), 2'(1 + k % 2)});
      rd(`MCS_OFS_STAT, d);
      if (len > 400) chk(d, {4'h0, 1'b1, 2'h0, k[0]});
      for (int w = 0; w < 20 && d[3] !== 1'b0; w++)
        rd(`MCS_OFS_STAT, d);
      chk(d, {7'h00, k[0]});
      rd(`MCS_OFS_CTRL, d);
      chk(d, {3'(t), 3'(p), 2'h0});
      chk(temp_data, exp_t);
      chk(press_data, exp_p);
    end
    $display("test single shot done");

    @(posedge clk);
    spin <= 1'b1;
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      stby_sel <= 3'(k);
      wr(`MCS_OFS_CTRL, 8'h27);
      gap(3000, n);
      gap(3000, n);
      chk(n >= CPM * ms[k] && n <= CPM * ms[k] + 2 * SC + 8, 1'b1);
      rd(`MCS_OFS_CTRL, d);
      chk(d, 8'h27);
    end
    wr(`MCS_OFS_CTRL, 8'h24);
    gap(1000, n);
    gap(1000, n);
    chk(n, 1000);
    $display("test continuous done");
    stop_test();
  end

endmodule : tb_top

`default_nettype wire
